// file: rtl/dtc_timer_unit.sv
// dual down-counting timer with waveform output and edge capture, Avalon-MM slave
//
// The Avalon-MM slave port is this design's own decision.
`timescale 1ns/10ps
`default_nettype none

// Operation
// - on enable outside demod narrow output takes initial level; loads low or high reload by it
// - single-pass narrow: count to zero, stop, toggle, set timeout status, interrupt
// - modulo-N narrow: first terminal count toggles only; later ones also flag
// - modulo-N narrow reloads low value if output now 0, else high value
// - reload registers writable anytime; take effect at next load
// - count of 1 forbidden; count 0 wraps narrow timer through ff to fe
// - narrow demod: falling edge count goes to high capture, others to low
// - after narrow capture set edge status, interrupt if enabled, reload ff
// - narrow demod reaching zero sets timeout status and keeps counting from ff
// - wide output while disabled and not forced is inverse of its initial-level bit
// - force bits 10 or 11 hold wide output at 0 or 1 always
// - on enable wide timer loads high*256+low and, outside demod, output takes initial level
// - wide reaching zero toggles output outside demod, sets timeout status, interrupts if enabled
// - wide stops after terminal count in single-pass, reloads in modulo-N
// - wide count 1 forbidden; count 0 wraps to ffff without timeout
// - wide demod: first selected edge captures, reloads and starts counting
// - later wide edges capture complemented count, flag, interrupt, reload ffff
// - capture registers read back captured byte; writes are ignored
// - wide capture high register holds msb, low register holds lsb
module dtc_timer_unit
    import dtc_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        timer_tick,
    input  wire logic        narrow_timer_input,
    input  wire logic        wide_timer_input,
    output logic             narrow_timer_output,
    output logic             wide_timer_output,
    output logic             narrow_timeout_irq,
    output logic             narrow_edge_irq,
    output logic             wide_timeout_irq,
    output logic             wide_edge_irq
);

    function automatic logic sel(input logic [3:0] a, input logic [3:0] idx);
        return a == idx;
    endfunction

    function automatic logic edge_hit(input dtc_pin_t p, input logic [1:0] s);
        return (s[0] & p.rise) | (s[1] & p.fall);
    endfunction

    dtc_narrow_ctl_t n_ctl_q;
    dtc_shared_ctl_t s_ctl_q;
    dtc_wide_ctl_t   w_ctl_q;
    logic [7:0]      n_rl_lo_q;
    logic [7:0]      n_rl_hi_q;
    logic [7:0]      w_rl_lo_q;
    logic [7:0]      w_rl_hi_q;
    logic [7:0]      n_cap_lo_q;
    logic [7:0]      n_cap_hi_q;
    logic [15:0]     w_cap_q;
    logic [7:0]      n_cnt_q;
    logic [15:0]     w_cnt_q;
    logic            n_out_q;
    logic            w_level_q;
    logic            w_out_q;
    logic            n_en_prev_q;
    logic            w_en_prev_q;
    logic            n_first_q;
    logic            w_armed_q;
    logic            n_to_st_q;
    logic            w_to_st_q;
    logic            rise_st_q;
    logic            fall_st_q;
    logic            ack_q;
    logic [31:0]     rdata_q;
    logic [7:0]      rd_mux;
    logic            n_irq_to_q;
    logic            n_irq_edge_q;
    logic            w_irq_to_q;
    logic            w_irq_edge_q;
    dtc_pin_t        n_pin;
    dtc_pin_t        w_pin;

    dtc_pin_sync u_narrow_sync (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .pin_in  (narrow_timer_input),
        .pin_ev  (n_pin)
    );

    dtc_pin_sync u_wide_sync (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .pin_in  (wide_timer_input),
        .pin_ev  (w_pin)
    );

    // bus: one wait cycle, request taken at the edge where waitrequest is low
    logic       wr_take;
    logic [7:0] wr_byte;
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
    assign wr_take         = avs_write & ack_q & avs_byteenable[0];
    assign wr_byte         = avs_writedata[7:0];
    assign avs_readdata    = rdata_q;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= (avs_read | avs_write) & ~ack_q;
        end
    end

    // narrow timer events
    logic n_start;
    logic n_run;
    logic n_tc;
    logic n_cap;
    logic n_zero;
    logic n_done;
    assign n_start = n_ctl_q.enable & ~n_en_prev_q;
    assign n_run   = n_ctl_q.enable & n_en_prev_q;
    assign n_tc    = n_run & ~n_ctl_q.demod & timer_tick & (n_cnt_q == DTC_NARROW_ONE);
    assign n_cap   = n_run & n_ctl_q.demod & edge_hit(n_pin, s_ctl_q.edge_sel);
    assign n_zero  = n_run & n_ctl_q.demod & timer_tick & ~n_cap & (n_cnt_q == DTC_NARROW_ONE);
    assign n_done  = n_tc & n_ctl_q.single_pass;

    // wide timer events
    logic w_start;
    logic w_run;
    logic w_counting;
    logic w_edge;
    logic w_first;
    logic w_cap;
    logic w_tc;
    logic w_done;
    assign w_start    = w_ctl_q.enable & ~w_en_prev_q;
    assign w_run      = w_ctl_q.enable & w_en_prev_q;
    assign w_counting = w_run & (~w_ctl_q.demod | ~w_armed_q);
    assign w_edge     = w_run & w_ctl_q.demod & edge_hit(w_pin, s_ctl_q.edge_sel);
    assign w_first    = w_edge & w_armed_q;
    assign w_cap      = w_edge & ~w_armed_q;
    assign w_tc       = w_counting & timer_tick & ~w_edge & (w_cnt_q == DTC_WIDE_ONE);
    assign w_done     = w_tc & ~w_ctl_q.demod & w_ctl_q.single_pass;

    // control and reload registers
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            n_ctl_q   <= DTC_CTL_RESET;
            s_ctl_q   <= DTC_CTL_RESET;
            w_ctl_q   <= DTC_CTL_RESET;
            n_rl_lo_q <= DTC_RELOAD_RESET;
            n_rl_hi_q <= DTC_RELOAD_RESET;
            w_rl_lo_q <= DTC_RELOAD_RESET;
            w_rl_hi_q <= DTC_RELOAD_RESET;
        end else begin
            if (wr_take && sel(avs_address, DTC_NARROW_CTL_IDX)) begin
                n_ctl_q            <= dtc_narrow_ctl_t'(wr_byte);
                n_ctl_q.timeout_st <= 1'b0;
            end else if (n_done) begin
                n_ctl_q.enable <= 1'b0;
            end
            if (wr_take && sel(avs_address, DTC_WIDE_CTL_IDX)) begin
                w_ctl_q            <= dtc_wide_ctl_t'(wr_byte);
                w_ctl_q.timeout_st <= 1'b0;
            end else if (w_done) begin
                w_ctl_q.enable <= 1'b0;
            end
            if (wr_take && sel(avs_address, DTC_SHARED_CTL_IDX)) begin
                s_ctl_q      <= dtc_shared_ctl_t'(wr_byte);
                s_ctl_q.rsvd <= 2'b00;
            end
            // reload values only reach the counter when it next loads
            if (wr_take && sel(avs_address, DTC_NARROW_RL_LO_IDX)) begin
                n_rl_lo_q <= wr_byte;
            end
            if (wr_take && sel(avs_address, DTC_NARROW_RL_HI_IDX)) begin
                n_rl_hi_q <= wr_byte;
            end
            if (wr_take && sel(avs_address, DTC_WIDE_RL_LO_IDX)) begin
                w_rl_lo_q <= wr_byte;
            end
            if (wr_take && sel(avs_address, DTC_WIDE_RL_HI_IDX)) begin
                w_rl_hi_q <= wr_byte;
            end
        end
    end

    // narrow counter, output and first-pass marker
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            n_cnt_q     <= DTC_NARROW_FULL;
            n_out_q     <= 1'b0;
            n_first_q   <= 1'b0;
            n_en_prev_q <= 1'b0;
        end else begin
            n_en_prev_q <= n_ctl_q.enable;
            if (n_start) begin
                n_cnt_q   <= n_ctl_q.demod ? DTC_NARROW_FULL :
                             (s_ctl_q.narrow_init ? n_rl_hi_q : n_rl_lo_q);
                n_first_q <= 1'b1;
                if (!n_ctl_q.demod) begin
                    n_out_q <= s_ctl_q.narrow_init;
                end
            end else if (n_cap) begin
                n_cnt_q <= DTC_NARROW_FULL;
            end else if (n_tc) begin
                n_out_q   <= ~n_out_q;
                n_first_q <= 1'b0;
                // new level 0 takes the low value, 1 the high value
                n_cnt_q   <= n_ctl_q.single_pass ? (n_cnt_q - DTC_NARROW_ONE) :
                             (n_out_q ? n_rl_lo_q : n_rl_hi_q);
            end else if (n_run && timer_tick) begin
                n_cnt_q <= n_cnt_q - DTC_NARROW_ONE;
            end
        end
    end

    // narrow captures: falling edge goes high, others low
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            n_cap_lo_q <= DTC_CAPTURE_RESET;
            n_cap_hi_q <= DTC_CAPTURE_RESET;
        end else if (n_cap) begin
            if (n_pin.fall) begin
                n_cap_hi_q <= n_cnt_q;
            end else begin
                n_cap_lo_q <= n_cnt_q;
            end
        end
    end

    // wide counter, waveform level and first-edge arming
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            w_cnt_q     <= DTC_WIDE_FULL;
            w_level_q   <= 1'b0;
            w_armed_q   <= 1'b0;
            w_en_prev_q <= 1'b0;
            w_cap_q     <= DTC_WIDE_CAP_RESET;
        end else begin
            w_en_prev_q <= w_ctl_q.enable;
            if (w_start) begin
                w_cnt_q   <= {w_rl_hi_q, w_rl_lo_q};
                w_armed_q <= w_ctl_q.demod;
                if (!w_ctl_q.demod) begin
                    w_level_q <= s_ctl_q.wide_init;
                end
            end else if (w_first) begin
                w_cap_q   <= ~w_cnt_q;
                w_cnt_q   <= {w_rl_hi_q, w_rl_lo_q};
                w_armed_q <= 1'b0;
            end else if (w_cap) begin
                w_cap_q <= ~w_cnt_q;
                w_cnt_q <= DTC_WIDE_FULL;
            end else if (w_tc && !w_ctl_q.demod) begin
                w_level_q <= ~w_level_q;
                w_cnt_q   <= w_ctl_q.single_pass ? (w_cnt_q - DTC_WIDE_ONE) :
                             {w_rl_hi_q, w_rl_lo_q};
            end else if (w_counting && timer_tick) begin
                // zero wraps to ffff; only reaching zero counts as timeout
                w_cnt_q <= w_cnt_q - DTC_WIDE_ONE;
            end
        end
    end

    // wide output pin with force and idle levels
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            w_out_q <= 1'b1;
        end else if (s_ctl_q.force_out[1]) begin
            w_out_q <= s_ctl_q.force_out[0];
        end else if (!w_ctl_q.enable) begin
            w_out_q <= ~s_ctl_q.wide_init;
        end else begin
            w_out_q <= w_level_q;
        end
    end

    assign narrow_timer_output = n_out_q;
    assign wide_timer_output   = w_out_q;

    // sticky status: hardware set wins over a write-one clear
    logic n_to_set;
    logic n_to_clr;
    logic w_to_clr;
    logic edge_clr;
    assign n_to_set = (n_tc & ~(~n_ctl_q.single_pass & n_first_q)) | n_zero;
    assign n_to_clr = wr_take & sel(avs_address, DTC_NARROW_CTL_IDX) & wr_byte[5];
    assign w_to_clr = wr_take & sel(avs_address, DTC_WIDE_CTL_IDX) & wr_byte[5];
    assign edge_clr = wr_take & sel(avs_address, DTC_SHARED_CTL_IDX);

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            n_to_st_q <= 1'b0;
            w_to_st_q <= 1'b0;
            rise_st_q <= 1'b0;
            fall_st_q <= 1'b0;
        end else begin
            n_to_st_q <= n_to_set | (n_to_st_q & ~n_to_clr);
            w_to_st_q <= w_tc | (w_to_st_q & ~w_to_clr);
            rise_st_q <= (n_cap & n_pin.rise) | (w_cap & w_pin.rise) |
                         (rise_st_q & ~(edge_clr & wr_byte[0]));
            fall_st_q <= (n_cap & n_pin.fall) | (w_cap & w_pin.fall) |
                         (fall_st_q & ~(edge_clr & wr_byte[1]));
        end
    end

    // interrupt requests: status gated by enables
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            n_irq_to_q   <= 1'b0;
            n_irq_edge_q <= 1'b0;
            w_irq_to_q   <= 1'b0;
            w_irq_edge_q <= 1'b0;
        end else begin
            n_irq_to_q   <= n_to_st_q & n_ctl_q.timeout_ie;
            n_irq_edge_q <= (rise_st_q | fall_st_q) & n_ctl_q.edge_ie;
            w_irq_to_q   <= w_to_st_q & w_ctl_q.timeout_ie;
            w_irq_edge_q <= (rise_st_q | fall_st_q) & w_ctl_q.edge_ie;
        end
    end

    assign narrow_timeout_irq = n_irq_to_q;
    assign narrow_edge_irq    = n_irq_edge_q;
    assign wide_timeout_irq   = w_irq_to_q;
    assign wide_edge_irq      = w_irq_edge_q;

    // read decode; in demod the shared low bits show edge status
    always_comb begin
        rd_mux = 8'h00;
        if (sel(avs_address, DTC_NARROW_CTL_IDX)) begin
            rd_mux    = n_ctl_q;
            rd_mux[5] = n_to_st_q;
        end else if (sel(avs_address, DTC_SHARED_CTL_IDX)) begin
            rd_mux = s_ctl_q;
            if (n_ctl_q.demod || w_ctl_q.demod) begin
                rd_mux[1:0] = {fall_st_q, rise_st_q};
            end
        end else if (sel(avs_address, DTC_WIDE_CTL_IDX)) begin
            rd_mux    = w_ctl_q;
            rd_mux[5] = w_to_st_q;
        end else if (sel(avs_address, DTC_NARROW_RL_LO_IDX)) begin
            rd_mux = n_rl_lo_q;
        end else if (sel(avs_address, DTC_NARROW_RL_HI_IDX)) begin
            rd_mux = n_rl_hi_q;
        end else if (sel(avs_address, DTC_WIDE_RL_LO_IDX)) begin
            rd_mux = w_rl_lo_q;
        end else if (sel(avs_address, DTC_WIDE_RL_HI_IDX)) begin
            rd_mux = w_rl_hi_q;
        end else if (sel(avs_address, DTC_WIDE_CAP_LO_IDX)) begin
            rd_mux = w_cap_q[7:0];
        end else if (sel(avs_address, DTC_WIDE_CAP_HI_IDX)) begin
            rd_mux = w_cap_q[15:8];
        end else if (sel(avs_address, DTC_NARROW_CAP_LO_IDX)) begin
            rd_mux = n_cap_lo_q;
        end else if (sel(avs_address, DTC_NARROW_CAP_HI_IDX)) begin
            rd_mux = n_cap_hi_q;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= 32'h0000_0000;
        end else if (avs_read && !ack_q) begin
            rdata_q <= {24'h00_0000, rd_mux};
        end
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    a_narrow_start_load: assert property (
        n_start && !n_ctl_q.demod |=> n_out_q == $past(s_ctl_q.narrow_init) &&
            n_cnt_q == ($past(s_ctl_q.narrow_init) ? $past(n_rl_hi_q) : $past(n_rl_lo_q)))
        else $error("narrow start level or load wrong");

    a_narrow_single_stop: assert property (
        n_done |=> !n_ctl_q.enable && n_to_st_q && n_cnt_q == 8'h00 &&
            n_out_q != $past(n_out_q))
        else $error("narrow single pass did not stop and flag");

    a_narrow_first_quiet: assert property (
        n_tc && !n_ctl_q.single_pass && n_first_q && !n_to_st_q |=> !n_to_st_q)
        else $error("narrow first terminal count flagged timeout");

    a_narrow_modn_reload: assert property (
        n_tc && !n_ctl_q.single_pass |=>
            n_cnt_q == (n_out_q ? $past(n_rl_hi_q) : $past(n_rl_lo_q)))
        else $error("narrow modulo reload picked wrong value");

    a_narrow_cap_route: assert property (
        n_cap && n_pin.fall |=> n_cap_hi_q == $past(n_cnt_q) && n_cnt_q == DTC_NARROW_FULL)
        else $error("narrow falling capture misrouted");

    a_narrow_zero_keep: assert property (
        n_zero |=> n_to_st_q && n_cnt_q == 8'h00 && n_ctl_q.enable ##1
            (!$past(timer_tick) || $past(n_cap) || !$past(n_run) ||
             n_cnt_q == DTC_NARROW_FULL))
        else $error("narrow demod zero not flagged or stalled");

    a_wide_idle_out: assert property (
        !w_ctl_q.enable && !s_ctl_q.force_out[1] |=> w_out_q == !$past(s_ctl_q.wide_init))
        else $error("wide idle output not inverse of initial level");

    a_wide_force_out: assert property (
        s_ctl_q.force_out[1] |=> w_out_q == $past(s_ctl_q.force_out[0]))
        else $error("wide output force ignored");

    a_wide_start_load: assert property (
        w_start && !w_ctl_q.demod |=> w_cnt_q == {$past(w_rl_hi_q), $past(w_rl_lo_q)})
        else $error("wide start load wrong");

    a_wide_cap_cpl: assert property (
        w_cap |=> w_cap_q == ~$past(w_cnt_q) && w_cnt_q == DTC_WIDE_FULL && $rose(w_armed_q) == 1'b0)
        else $error("wide capture not complemented or not reloaded");

    a_wide_zero_wrap: assert property (
        w_counting && timer_tick && !w_edge && w_cnt_q == 16'h0000 && !w_to_st_q |=>
            !w_to_st_q && w_cnt_q == DTC_WIDE_FULL)
        else $error("wide wrap from zero treated as timeout");

    c_narrow_modn: cover property (n_tc && !n_ctl_q.single_pass && !n_first_q);
    c_wide_capture: cover property (w_first ##[1:1000] w_cap);
    c_wide_single: cover property (w_done);
    c_narrow_fall: cover property (n_cap && n_pin.fall);

endmodule

`default_nettype wire

// file: rtl/dtc_pkg.sv
// register map, field layouts and constants of the dual timer capture unit
package dtc_pkg;

    // word index of each register; the byte address is four times the index
    localparam logic [3:0] DTC_NARROW_CTL_IDX   = 4'h0;
    localparam logic [3:0] DTC_SHARED_CTL_IDX   = 4'h1;
    localparam logic [3:0] DTC_WIDE_CTL_IDX     = 4'h2;
    localparam logic [3:0] DTC_NARROW_RL_LO_IDX = 4'h4;
    localparam logic [3:0] DTC_NARROW_RL_HI_IDX = 4'h5;
    localparam logic [3:0] DTC_WIDE_RL_LO_IDX   = 4'h6;
    localparam logic [3:0] DTC_WIDE_RL_HI_IDX   = 4'h7;
    localparam logic [3:0] DTC_WIDE_CAP_LO_IDX  = 4'h8;
    localparam logic [3:0] DTC_WIDE_CAP_HI_IDX  = 4'h9;
    localparam logic [3:0] DTC_NARROW_CAP_LO_IDX = 4'ha;
    localparam logic [3:0] DTC_NARROW_CAP_HI_IDX = 4'hb;

    // reset values
    localparam logic [7:0]  DTC_CTL_RESET     = 8'h00;
    localparam logic [7:0]  DTC_RELOAD_RESET  = 8'h00;
    localparam logic [7:0]  DTC_CAPTURE_RESET = 8'h00;
    localparam logic [15:0] DTC_WIDE_CAP_RESET = 16'h0000;

    // counter constants
    localparam logic [7:0]  DTC_NARROW_FULL = 8'hff;
    localparam logic [7:0]  DTC_NARROW_ONE  = 8'h01;
    localparam logic [15:0] DTC_WIDE_FULL   = 16'hffff;
    localparam logic [15:0] DTC_WIDE_ONE    = 16'h0001;

    // narrow timer control, bit 7 down to bit 0
    typedef struct packed {
        logic       enable;
        logic       single_pass;
        logic       timeout_st;
        logic       demod;
        logic       rsvd3;
        logic       edge_ie;
        logic       timeout_ie;
        logic       rsvd0;
    } dtc_narrow_ctl_t;

    // shared control; edge_sel bit 0 picks rising, bit 1 falling edges
    typedef struct packed {
        logic [1:0] rsvd;
        logic [1:0] edge_sel;
        logic [1:0] force_out;
        logic       narrow_init;
        logic       wide_init;
    } dtc_shared_ctl_t;

    // wide timer control, bit 7 down to bit 0
    typedef struct packed {
        logic       enable;
        logic       capture_mode;
        logic       timeout_st;
        logic       demod;
        logic       rsvd3;
        logic       edge_ie;
        logic       timeout_ie;
        logic       single_pass;
    } dtc_wide_ctl_t;

    // filtered pin level with one-cycle edge pulses
    typedef struct packed {
        logic       level;
        logic       rise;
        logic       fall;
    } dtc_pin_t;

endpackage

// file: rtl/dtc_pin_sync.sv
// three-stage pin synchroniser with agreement filter and edge pulses
`timescale 1ns/10ps
`default_nettype none

module dtc_pin_sync
    import dtc_pkg::*;
(
    input  wire logic     sys_clk,
    input  wire logic     rst_n,
    input  wire logic     pin_in,
    output var  dtc_pin_t pin_ev
);

    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic level_q;
    logic rise_q;
    logic fall_q;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else begin
            s1_q <= pin_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // a change counts once stages two and three agree
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            level_q <= 1'b0;
            rise_q  <= 1'b0;
            fall_q  <= 1'b0;
        end else begin
            rise_q <= (s2_q == s3_q) && s2_q && !level_q;
            fall_q <= (s2_q == s3_q) && !s2_q && level_q;
            if (s2_q == s3_q) begin
                level_q <= s2_q;
            end
        end
    end

    assign pin_ev = '{level: level_q, rise: rise_q, fall: fall_q};

endmodule

`default_nettype wire

// file: tb/dtc_pin_src.sv
// pin stimulus source: square wave with a programmable half period
`timescale 1ns/10ps
`default_nettype none

module dtc_pin_src (
    input  wire logic       sys_clk,
    input  wire logic [7:0] half,
    output logic            pin
);
    logic [7:0] cnt_q;

    initial begin
        pin = 1'b0;
        cnt_q = 8'h00;
    end

    // half of zero parks the pin low, otherwise it toggles every half+1 cycles
    always @(posedge sys_clk) begin
        cnt_q <= (half == 8'h00 || cnt_q == half) ? 8'h00 : cnt_q + 8'h01;
        if (half == 8'h00)
            pin <= 1'b0;
        else if (cnt_q == half)
            pin <= ~pin;
    end
endmodule

`default_nettype wire

// file: tb/dual_timer_capture_unit_tb_top.sv
// self-checking bench of the dual timer capture unit
`timescale 1ns/10ps
`default_nettype none

module dual_timer_capture_unit_tb_top
    import dtc_pkg::*;
;
    logic        sys_clk, rst_n, avs_read, avs_write, timer_tick, n_pin, w_pin, avs_waitrequest;
    logic        n_out, w_out, n_to, n_ed, w_to, w_ed;
    logic [3:0]  avs_address, avs_byteenable;
    logic [31:0] avs_writedata, avs_readdata, seed, rd;
    logic [7:0]  half, cnt;
    logic [7:0]  sh [4] = '{8'h00, 8'h01, 8'h08, 8'h0d};
    int          fail_count, check_count, k;

    dtc_pin_src dtc_pin_src_inst (.sys_clk(sys_clk), .half(half), .pin(n_pin));
    dtc_timer_unit dtc_timer_unit_inst (.sys_clk(sys_clk), .rst_n(rst_n),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .timer_tick(timer_tick), .narrow_timer_input(n_pin), .wide_timer_input(w_pin),
        .narrow_timer_output(n_out), .wide_timer_output(w_out), .narrow_timeout_irq(n_to),
        .narrow_edge_irq(n_ed), .wide_timeout_irq(w_to), .wide_edge_irq(w_ed));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic [31:0] near_de(input logic [7:0] v);
        return {31'h0, v >= 8'hdc && v <= 8'he0};
    endfunction

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task test_done;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // request held until waitrequest is sampled low at a rising edge
    task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_write <= w;
        avs_read <= ~w;
        do @(posedge sys_clk); while (avs_waitrequest !== 1'b0 && ++n < 50);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (n >= 50) begin
            fail_count++;
            test_done;
        end
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    initial begin
        repeat (20000) @(posedge sys_clk);
        fail_count++;
        test_done;
    end

    initial begin
        {rst_n, avs_read, avs_write, timer_tick, w_pin, avs_address} = '0;
        {avs_writedata, half, fail_count, check_count} = '0;
        avs_byteenable = 4'h1;
        seed = 32'h72ae;
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        timer_tick <= 1'b1;
        @(negedge sys_clk);
        chk("outputs", 32'h1, {30'h0, n_out, w_out});
        for (int i = 0; i < 12; i++) begin
            seed = lfsr(seed);
            bus(1'b1, 4'(i), (i < 3) ? 8'h00 : seed[7:0]);
            bus(1'b0, 4'(i), 8'h00);
            chk("reg", (i > 3 && i < 8) ? {24'h0, seed[7:0]} : 32'h0, rd);
        end
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, DTC_SHARED_CTL_IDX, sh[i]);
            repeat (2) @(negedge sys_clk);
            chk("wide_out", {31'h0, 1'(4'b1001 >> i)}, {31'h0, w_out});
        end
        bus(1'b1, DTC_SHARED_CTL_IDX, 8'h00);
        cnt = 8'h02 + {4'h0, seed[3:0]};
        bus(1'b1, DTC_NARROW_RL_LO_IDX, cnt);
        bus(1'b1, DTC_NARROW_CTL_IDX, 8'hc2);
        k = 0;
        do @(negedge sys_clk); while (n_out !== 1'b1 && ++k < 300);
        chk("narrow_period", {24'h0, cnt} + 32'h1, k);
        @(negedge sys_clk);
        chk("narrow_irq", 32'h1, {31'h0, n_to});
        bus(1'b0, DTC_NARROW_CTL_IDX, 8'h00);
        chk("narrow_ctl", 32'h62, rd);
        bus(1'b1, DTC_NARROW_CTL_IDX, 8'h20);
        bus(1'b1, DTC_SHARED_CTL_IDX, 8'h30);
        bus(1'b1, DTC_NARROW_CTL_IDX, 8'h94);
        half <= 8'h20;
        repeat (280) @(posedge sys_clk);
        half <= 8'h00;
        @(negedge sys_clk);
        chk("edge_irq", 32'h1, {31'h0, n_ed});
        bus(1'b0, DTC_SHARED_CTL_IDX, 8'h00);
        chk("edge_status", 32'h3, {30'h0, rd[1:0]});
        bus(1'b0, DTC_NARROW_CAP_HI_IDX, 8'h00);
        chk("cap_hi", 32'h1, near_de(rd[7:0]));
        bus(1'b0, DTC_NARROW_CAP_LO_IDX, 8'h00);
        chk("cap_lo", 32'h1, near_de(rd[7:0]));
        bus(1'b1, DTC_WIDE_RL_LO_IDX, cnt);
        bus(1'b1, DTC_WIDE_RL_HI_IDX, 8'h00);
        bus(1'b1, DTC_WIDE_CTL_IDX, 8'h83);
        k = 0;
        do @(negedge sys_clk); while (w_to !== 1'b1 && ++k < 300);
        chk("wide_period", {24'h0, cnt} + 32'h2, k);
        chk("wide_edge_irq", 32'h0, {31'h0, w_ed});
        bus(1'b0, DTC_WIDE_CTL_IDX, 8'h00);
        chk("wide_ctl", 32'h23, rd);
        bus(1'b1, DTC_WIDE_RL_LO_IDX, 8'hff);
        bus(1'b1, DTC_WIDE_RL_HI_IDX, 8'hff);
        bus(1'b1, DTC_SHARED_CTL_IDX, 8'h33);
        bus(1'b1, DTC_WIDE_CTL_IDX, 8'h94);
        w_pin <= 1'b1;
        repeat (20) @(posedge sys_clk);
        chk("wide_first_quiet", 32'h0, {31'h0, w_ed});
        w_pin <= 1'b0;
        repeat (20) @(posedge sys_clk);
        chk("wide_edge_irq", 32'h1, {31'h0, w_ed});
        bus(1'b0, DTC_WIDE_CAP_LO_IDX, 8'h00);
        chk("wide_cap_lo", 32'h13, rd);
        bus(1'b0, DTC_WIDE_CAP_HI_IDX, 8'h00);
        chk("wide_cap_hi", 32'h0, rd);
        repeat (260) @(posedge sys_clk);
        bus(1'b0, DTC_NARROW_CTL_IDX, 8'h00);
        chk("narrow_demod_ctl", 32'hb4, rd);
        test_done;
    end
endmodule

`default_nettype wire
